// ===== umc_defines.svh
`ifndef UMC_DEFINES_SVH
`define UMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UMC_MODE_OFFSET      8'h00
`define UMC_STATUS_OFFSET    8'h04

// ----------------------------------------------------------------------
// Mode register field positions
// ----------------------------------------------------------------------
`define UMC_ENABLE_BIT       15
`define UMC_IDLE_STOP_BIT    13
`define UMC_IR_BIT           12
`define UMC_RTS_MODE_BIT     11
`define UMC_PIN_SEL_HI       9
`define UMC_PIN_SEL_LO       8
`define UMC_WAKE_BIT         7
`define UMC_LOOPBACK_BIT     6
`define UMC_LOW_FIELD_HI     5
`define UMC_LOW_FIELD_LO     0
`define UMC_AUTO_BAUD_BIT    5
`define UMC_RX_INVERT_BIT    4
`define UMC_BAUD_SPEED_BIT   3
`define UMC_PARITY_HI        2
`define UMC_PARITY_LO        1
`define UMC_STOP_BIT         0

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define UMC_MODE_RESET       32'h0000_0000
`define UMC_MODE_WMASK       32'h0000_bbff
`define UMC_SYNC_RESET       3'h4

`endif

// ===== umc_mode_control.sv
`timescale 1ns/1ps
`include "umc_defines.svh"

// Functional notes
// - Enable bit 15 set gives pins to unit per pin-select and transmit enable
// - Enable clear hands all pins to port logic; unit activity minimal
// - Idle-stop bit 13 set halts the unit during chip idle mode
// - Bit 12 inserts infrared encoder/decoder into the serial path
// - Bit 11: 1 selects simplex request pin, 0 flow control
// - Pin-select bits 9-8 choose which pins the unit uses
// - Bit 7 set makes a receive start bit during sleep raise wake-up
// - Bit 6 set loops transmit output internally back to receiver
// - Bits 31-16, 14 and 10 read as zero
module umc_mode_control (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  input  wire logic                  transmit_enable,
  input  wire logic                  chip_idle,
  input  wire logic                  chip_sleep,
  input  wire logic                  receive_pin,
  input  wire logic                  unit_tx_data,
  input  wire logic                  unit_rts_n,
  input  wire logic                  unit_bclk,
  output umc_pkg::umc_pin_own_t      pin_own,
  output umc_pkg::umc_ctrl_t         ctrl,
  output logic                       transmit_pin,
  output logic                       request_to_send_pin,
  output logic                       baud_clock_out_pin,
  output logic                       unit_rx_data,
  output logic                       unit_cts_sel,
  output logic                       wake_req
);
  import umc_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  localparam logic [2:0] SYNC_IDLE = `UMC_SYNC_RESET;

  logic [2:0] async_in;
  logic [2:0] sync_out;
  logic       rx_prev_reg;

  assign async_in = {receive_pin, chip_idle, chip_sleep};

  // Chains reset to each pin's idle level, so no false start bit follows reset
  for (genvar g = 0; g < 3; g++) begin : g_sync
    logic s1_reg;
    logic s2_reg;

    always_ff @(posedge clk) begin
      if (rst) begin
        s1_reg <= SYNC_IDLE[g];
        s2_reg <= SYNC_IDLE[g];
      end else begin
        s1_reg <= async_in[g];
        s2_reg <= s1_reg;
      end
    end

    // Only the second stage leaves the chain
    assign sync_out[g] = s2_reg;
  end

  logic rx_s;
  logic idle_s;
  logic sleep_s;
  assign rx_s    = sync_out[2];
  assign idle_s  = sync_out[1];
  assign sleep_s = sync_out[0];

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] mode_next;

  always_comb begin
    mode_next = mode_reg;
    if (reg_wr && reg_addr == `UMC_MODE_OFFSET) begin
      // Unimplemented bits never store, so they read back as zero
      mode_next = reg_wdata & `UMC_MODE_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= `UMC_MODE_RESET;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Decoded fields shared by the state machine and the output flops
  logic         en;
  logic         idle_stop;
  umc_pin_sel_t pin_sel;
  assign en        = mode_reg[`UMC_ENABLE_BIT];
  assign idle_stop = mode_reg[`UMC_IDLE_STOP_BIT];
  assign pin_sel   = umc_pin_sel_t'(mode_reg[`UMC_PIN_SEL_HI:`UMC_PIN_SEL_LO]);

  // ----------------------------------------------------------------------
  // Operating state
  // ----------------------------------------------------------------------
  umc_state_t state_reg;
  umc_state_t state_next;

  // Halt is rechecked every cycle, so leaving idle resumes without a write
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UMC_OFF: begin
        if (en) begin
          state_next = (idle_stop && idle_s) ? UMC_IDLE_HALT : UMC_RUN;
        end
      end
      UMC_RUN: begin
        if (!en) begin
          state_next = UMC_OFF;
        end else if (idle_stop && idle_s) begin
          state_next = UMC_IDLE_HALT;
        end
      end
      UMC_IDLE_HALT: begin
        if (!en) begin
          state_next = UMC_OFF;
        end else if (!(idle_stop && idle_s)) begin
          state_next = UMC_RUN;
        end
      end
      default: state_next = UMC_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= UMC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin ownership
  // ----------------------------------------------------------------------
  function automatic umc_pin_own_t pin_decode(input logic on, input umc_pin_sel_t sel,
                                              input logic txen);
    umc_pin_own_t o;
    o = '0;
    if (on) begin
      o.tx   = txen;
      o.rx   = 1'b1;
      o.cts  = (sel == UMC_PINS_FULL_FLOW);
      o.rts  = (sel == UMC_PINS_FULL_FLOW) || (sel == UMC_PINS_TX_RX_RTS);
      o.bclk = (sel == UMC_PINS_TX_RX_BCLK);
    end
    return o;
  endfunction : pin_decode

  // Decoded from the stored mode, so pins move one edge after the register
  umc_pin_own_t own_next;
  assign own_next = pin_decode(en, pin_sel, transmit_enable);

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_own <= '0;
    end else begin
      pin_own <= own_next;
    end
  end

  // ----------------------------------------------------------------------
  // Controls to the serial datapath
  // ----------------------------------------------------------------------
  logic       run_reg;
  logic [3:0] mode_ctl_reg;
  logic [5:0] low_fields_reg;

  // Run flag tracks the next state so it changes on the same edge as pin_own
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= 1'b0;
    end else begin
      run_reg <= (state_next == UMC_RUN);
    end
  end

  // Enable gating keeps the infrared and loopback paths quiet while off
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_ctl_reg <= 4'h0;
    end else begin
      mode_ctl_reg <= {en & transmit_enable,
                       en & mode_reg[`UMC_IR_BIT],
                       mode_reg[`UMC_RTS_MODE_BIT],
                       en & mode_reg[`UMC_LOOPBACK_BIT]};
    end
  end

  // Low-byte fields are only stored here; the datapath gives them meaning
  always_ff @(posedge clk) begin
    if (rst) begin
      low_fields_reg <= 6'h00;
    end else begin
      low_fields_reg <= {mode_reg[`UMC_BAUD_SPEED_BIT],
                         mode_reg[`UMC_PARITY_HI:`UMC_PARITY_LO],
                         mode_reg[`UMC_STOP_BIT],
                         mode_reg[`UMC_AUTO_BAUD_BIT],
                         mode_reg[`UMC_RX_INVERT_BIT]};
    end
  end

  // Field order matches the struct: run, four mode controls, six low-byte bits
  assign ctrl = {run_reg, mode_ctl_reg, low_fields_reg};

  // ----------------------------------------------------------------------
  // Pin data path and loopback
  // ----------------------------------------------------------------------
  logic lpb;
  assign lpb = en & mode_reg[`UMC_LOOPBACK_BIT];

  // Serial data: loopback turns the transmit bit back into the receiver
  always_ff @(posedge clk) begin
    if (rst) begin
      transmit_pin <= 1'b1;
      unit_rx_data <= 1'b1;
    end else begin
      // Line idles high while looped back so the remote sees no traffic
      transmit_pin <= (own_next.tx && !lpb) ? unit_tx_data : 1'b1;
      unit_rx_data <= lpb ? unit_tx_data : (en ? rx_s : 1'b1);
    end
  end

  // Handshake pins: unowned pins rest at their inactive level
  always_ff @(posedge clk) begin
    if (rst) begin
      request_to_send_pin <= 1'b1;
      baud_clock_out_pin  <= 1'b0;
      unit_cts_sel        <= 1'b0;
    end else begin
      request_to_send_pin <= own_next.rts ? unit_rts_n : 1'b1;
      baud_clock_out_pin  <= own_next.bclk ? unit_bclk : 1'b0;
      unit_cts_sel        <= own_next.cts;
    end
  end

  // ----------------------------------------------------------------------
  // Wake on start bit
  // ----------------------------------------------------------------------
  // Previous line level, reset high to match the idle line
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_s;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      // Falling edge of the line is the start bit
      wake_req <= en & mode_reg[`UMC_WAKE_BIT] & sleep_s & rx_prev_reg & ~rx_s;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  // Status word: state and pin ownership, read-only
  logic [31:0] status_word;
  assign status_word = {22'h0, (state_reg == UMC_IDLE_HALT), (state_reg == UMC_RUN),
                        3'h0, pin_own};

  // Zero outside the read cycle, so stale data never lingers on the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      // No stall exists, so an access right after disabling is merely stale
      if (reg_addr == `UMC_MODE_OFFSET) begin
        reg_rdata <= mode_reg;
      end else if (reg_addr == `UMC_STATUS_OFFSET) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule : umc_mode_control

// ===== umc_mode_control_chk.sv
`timescale 1ns/1ps
module umc_mode_control_chk (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic [7:0]       reg_addr,
  input wire logic [31:0]      reg_wdata,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  input wire umc_pkg::umc_pin_own_t pin_own,
  input wire umc_pkg::umc_ctrl_t    ctrl,
  input wire logic             transmit_pin,
  input wire logic             wake_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic mw;
  assign mw = reg_wr && reg_addr == 8'h00;
  property p_rdz; reg_rd |=> reg_rdata[31:16] == 16'h0 && !reg_rdata[14] && !reg_rdata[10];
  endproperty
  a_rdz: assert property (p_rdz) else $error("reserved bits set");
  property p_off; mw && !reg_wdata[15] |-> ##2 pin_own == '0; endproperty
  a_off: assert property (p_off) else $error("pins kept when off");
  property p_m3; mw && reg_wdata[15] && reg_wdata[9:8] == 2'h3 |-> ##2
    pin_own.rx && pin_own.bclk && !pin_own.cts && !pin_own.rts; endproperty
  a_m3: assert property (p_m3) else $error("pin mode 3");
  property p_m2; mw && reg_wdata[15] && reg_wdata[9:8] == 2'h2 |-> ##2
    pin_own.cts && pin_own.rts && !pin_own.bclk; endproperty
  a_m2: assert property (p_m2) else $error("pin mode 2");
  property p_fld; mw |-> ##2 ctrl.infrared_codec_enable ==
    ($past(reg_wdata[15], 2) & $past(reg_wdata[12], 2)) &&
    ctrl.request_pin_mode == $past(reg_wdata[11], 2) &&
    ctrl.loopback_select == ($past(reg_wdata[15], 2) & $past(reg_wdata[6], 2)); endproperty
  a_fld: assert property (p_fld) else $error("mode field");
  property p_low; mw |-> ##2 ctrl.stop_bit_select == $past(reg_wdata[0], 2) &&
    ctrl.parity_data_select == $past(reg_wdata[2:1], 2) &&
    ctrl.high_speed_baud == $past(reg_wdata[3], 2) &&
    ctrl.receive_invert == $past(reg_wdata[4], 2) &&
    ctrl.auto_baud_enable == $past(reg_wdata[5], 2); endproperty
  a_low: assert property (p_low) else $error("low field");
  property p_run; !pin_own.rx |-> !ctrl.run; endproperty
  a_run: assert property (p_run) else $error("runs while off");
  property p_wake; wake_req |-> pin_own.rx ##1 !wake_req; endproperty
  a_wake: assert property (p_wake) else $error("wake pulse");
  property p_lb; ctrl.loopback_select && $past(ctrl.loopback_select) |-> transmit_pin;
  endproperty
  a_lb: assert property (p_lb) else $error("tx pin in loopback");
  c_wake: cover property (wake_req);
  c_lb: cover property (ctrl.loopback_select);
  c_halt: cover property (pin_own.rx && !ctrl.run);
endmodule : umc_mode_control_chk
bind umc_mode_control umc_mode_control_chk i_umc_mode_control_chk (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_own(pin_own), .ctrl(ctrl), .transmit_pin(transmit_pin),
  .wake_req(wake_req));

// ===== umc_mode_control_tb.sv
`timescale 1ns/1ps
`include "umc_defines.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module umc_mode_control_tb;
  import umc_pkg::*;
  logic clk, rst, wr, rd, txen, idle, sleep, rxp, utx, send, tp, rts, bclk, urx, cts, wk;
  logic urts, ubclk;
  logic [7:0]   addr;
  logic [31:0]  wdata, rdata, d;
  umc_pin_own_t own;
  umc_ctrl_t    ctl;
  int n_fail, n_compared, n_wake, i;
  logic [36:0]  rows [5] = '{{32'hffffffff, 5'h19}, {32'h00008200, 5'h1e},
    {32'h00008100, 5'h1a}, {32'h00008000, 5'h18}, {32'h00007fff, 5'h00}};
  umc_mode_control i_umc_mode_control (.clk(clk), .rst(rst), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .transmit_enable(txen),
    .chip_idle(idle), .chip_sleep(sleep), .receive_pin(rxp), .unit_tx_data(utx),
    .unit_rts_n(urts), .unit_bclk(ubclk), .pin_own(own), .ctrl(ctl), .transmit_pin(tp),
    .request_to_send_pin(rts), .baud_clock_out_pin(bclk), .unit_rx_data(urx),
    .unit_cts_sel(cts), .wake_req(wk));
  umc_remote_dev i_umc_remote_dev (.clk(clk), .send(send), .line(rxp));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (wk === 1'b1) n_wake++;
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic end_of_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  initial begin
    #400000 n_fail++;
    end_of_test;
  end
  initial begin
    {rst, wr, rd, idle, sleep, utx, send} = 7'h42;
    {urts, ubclk} = 2'h1;
    {txen, addr, wdata} = '1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK({own, tp}, 6'h01)
    for (i = 0; i < 5; i++) begin
      wr_reg(`UMC_MODE_OFFSET, rows[i][36:5]);
      repeat (3) @(posedge clk);
      `CHK(own, rows[i][4:0])
      `CHK({rts, bclk, cts}, {~rows[i][1], rows[i][0], rows[i][2]})
      rd_reg(`UMC_MODE_OFFSET, d);
      `CHK(d, rows[i][36:5] & `UMC_MODE_WMASK)
      repeat (2) @(posedge clk); // Gap after each row's write and read-back
    end
    rd_reg(8'h08, d);
    `CHK(d, 32'h0)
    wr_reg(`UMC_MODE_OFFSET, 32'h00008000);
    txen <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK({own.tx, own.rx, ctl.transmit_enable, tp}, 4'h5)
    rd_reg(`UMC_STATUS_OFFSET, d);
    `CHK(d, 32'h00000108)
    @(posedge clk) txen <= 1'b1;
    wr_reg(`UMC_MODE_OFFSET, 32'h0000a000);
    idle <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(ctl.run, 1'b0)
    wr_reg(`UMC_MODE_OFFSET, 32'h00008000);
    repeat (6) @(posedge clk);
    `CHK(ctl.run, 1'b1)
    wr_reg(`UMC_MODE_OFFSET, 32'h00008040);
    utx <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK({urx, tp}, 2'h1)
    wr_reg(`UMC_MODE_OFFSET, 32'h00009880);
    {sleep, utx} <= 2'h3;
    n_wake = 0;
    repeat (4) @(posedge clk);
    send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(urx, 1'b0)
    repeat (15) @(posedge clk);
    `CHK(n_wake, 1)
    `CHK({ctl.infrared_codec_enable, ctl.request_pin_mode}, 2'h3)
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 `CHK({own, tp, ctl, wk}, {5'h00, 1'b1, 11'h000, 1'b0})
    rd_reg(`UMC_MODE_OFFSET, d);
    `CHK(d, `UMC_MODE_RESET)
    end_of_test;
  end
endmodule : umc_mode_control_tb

// ===== umc_pkg.sv
package umc_pkg;

  typedef enum logic [1:0] {
    UMC_PINS_TX_RX      = 2'h0,
    UMC_PINS_TX_RX_RTS  = 2'h1,
    UMC_PINS_FULL_FLOW  = 2'h2,
    UMC_PINS_TX_RX_BCLK = 2'h3
  } umc_pin_sel_t;

  // Ownership of each serial pin: 1 = serial unit, 0 = general port
  typedef struct packed {
    logic tx;
    logic rx;
    logic cts;
    logic rts;
    logic bclk;
  } umc_pin_own_t;

  // Controls handed to the rest of the serial unit
  typedef struct packed {
    logic       run;
    logic       transmit_enable;
    logic       infrared_codec_enable;
    logic       request_pin_mode;
    logic       loopback_select;
    logic       high_speed_baud;
    logic [1:0] parity_data_select;
    logic       stop_bit_select;
    logic       auto_baud_enable;
    logic       receive_invert;
  } umc_ctrl_t;

  typedef enum {
    UMC_OFF,
    UMC_RUN,
    UMC_IDLE_HALT
  } umc_state_t;

endpackage : umc_pkg

// ===== umc_remote_dev.sv
`timescale 1ns/1ps
// Far-end serial device: idles high, sends one start bit on request
module umc_remote_dev (
  input  wire logic clk,
  input  wire logic send,
  output logic      line
);
  logic [3:0] cnt_reg;
  initial begin
    line = 1'b1;
    cnt_reg = 4'h0;
  end
  always @(posedge clk) begin
    if (send) cnt_reg <= 4'ha;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    line <= !(send || cnt_reg > 4'h1);
  end
endmodule : umc_remote_dev
